// *** hw/pfc_pll_feed_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module pfc_pll_feed_control (
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire pfc_pkg::pfc_bus_req_type bus_req,
    output logic [15:0]                   bus_rdata,
    input  wire logic                     power_down_enter,
    input  wire logic                     lock_raw,
    output logic                          lock_flag,
    output logic                          mult_run,
    output logic                          mult_clock_select,
    output logic [5:0]                    mult_factor,
    output logic [4:0]                    cco_divide
);
    import pfc_pkg::*;

    typedef struct packed {
        logic [1:0]  pend_ctl;
        logic [6:0]  pend_cfg;
        logic        act_en;
        logic        act_con;
        logic [4:0]  act_multiplier_field;
        logic [1:0]  act_psel;
        logic        lock_meta;
        logic        lock_sync;
        logic [15:0] rdata;
        logic        run;
        logic        sel;
        logic [5:0]  factor;
        logic [4:0]  div;
    } pfc_state_type;

    pfc_state_type s_q;
    pfc_state_type s_d;
    logic          commit;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // a shift instead of a table: every divider code is a power of two
    function automatic logic [4:0] pfc_div_of(input logic [1:0] psel);
        pfc_div_of = 5'h02 << psel;
    endfunction

    function automatic logic [15:0] pfc_status(input pfc_state_type s);
        pfc_status = '0;
        pfc_status[PFC_MULTIPLIER_FIELD_LSB +: 5] = s.act_multiplier_field;
        pfc_status[PFC_PSEL_LSB +: 2] = s.act_psel;
        pfc_status[PFC_STAT_EN_BIT]   = s.act_en;
        pfc_status[PFC_STAT_CON_BIT]  = s.act_con;
        pfc_status[PFC_STAT_LCK_BIT]  = s.lock_sync;
    endfunction

    pfc_unlock_tracker u_tracker (
        .clock  (clock),
        .rst    (rst),
        .req    (bus_req),
        .commit (commit)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.lock_meta = lock_raw;
        s_d.lock_sync = s_q.lock_meta;
        if (bus_req.valid && bus_req.write) begin
            if (bus_req.addr == PFC_CTL_ADDR) begin
                s_d.pend_ctl = bus_req.wdata[1:0];
            end
            if (bus_req.addr == PFC_CFG_ADDR) begin
                s_d.pend_cfg = bus_req.wdata[6:0];
            end
        end
        if (commit) begin
            s_d.act_en   = s_q.pend_ctl[PFC_CTL_EN_BIT];
            s_d.act_con  = s_q.pend_ctl[PFC_CTL_CON_BIT];
            s_d.act_multiplier_field = s_q.pend_cfg[PFC_MULTIPLIER_FIELD_LSB +: 5];
            s_d.act_psel = s_q.pend_cfg[PFC_PSEL_LSB +: 2];
        end
        // power down wins over the enable and connect of a commit in the same cycle; pending
        // values stay so software can see what it last wrote
        if (power_down_enter) begin
            s_d.act_en  = 1'b0;
            s_d.act_con = 1'b0;
        end
        s_d.run    = s_d.act_en;
        s_d.sel    = s_d.act_en && s_d.act_con;
        s_d.factor = {1'b0, s_d.act_multiplier_field} + 6'h01;
        s_d.div    = pfc_div_of(s_d.act_psel);
        if (bus_req.valid && !bus_req.write) begin
            case (bus_req.addr)
                PFC_CTL_ADDR:  s_d.rdata = {14'h0000, s_q.pend_ctl};
                PFC_CFG_ADDR:  s_d.rdata = {9'h000, s_q.pend_cfg};
                PFC_STAT_ADDR: s_d.rdata = pfc_status(s_q);
                default:       s_d.rdata = PFC_RDATA_RESET;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_q <= '{pend_ctl: PFC_CTL_RESET,
                     pend_cfg: {PFC_PSEL_RESET, PFC_MULTIPLIER_FIELD_RESET},
                     act_en: 1'b0, act_con: 1'b0,
                     act_multiplier_field: PFC_MULTIPLIER_FIELD_RESET, act_psel: PFC_PSEL_RESET,
                     lock_meta: 1'b0, lock_sync: 1'b0,
                     rdata: PFC_RDATA_RESET, run: 1'b0, sel: 1'b0,
                     factor: PFC_FACTOR_RESET, div: PFC_DIV_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    assign bus_rdata         = s_q.rdata;
    assign lock_flag         = s_q.lock_sync;
    assign mult_run          = s_q.run;
    assign mult_clock_select = s_q.sel;
    assign mult_factor       = s_q.factor;
    assign cco_divide        = s_q.div;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    // outputs are registered copies, so most checks look one edge back
    sequence seq_first_key;
        bus_req.valid && bus_req.write && bus_req.addr == PFC_UNLOCK_ADDR
            && bus_req.wdata == PFC_KEY_FIRST;
    endsequence

    sequence seq_second_key;
        bus_req.valid && bus_req.write && bus_req.addr == PFC_UNLOCK_ADDR
            && bus_req.wdata == PFC_KEY_SECOND;
    endsequence

    chk_pair_commit: assert property (
        seq_first_key ##1 (seq_second_key and !power_down_enter)
            ##1 !power_down_enter
        |=> s_q.act_en == $past(s_q.pend_ctl[0], 2)
            && s_q.act_multiplier_field == $past(s_q.pend_cfg[4:0], 2))
        else $error("unlock pair did not commit pending values");

    chk_bad_hold: assert property (
        !commit |=> $stable(s_q.act_multiplier_field) && $stable(s_q.act_psel))
        else $error("active settings changed without commit");

    chk_pd_clear: assert property (
        power_down_enter |=> !s_q.act_en && !s_q.act_con
            && !mult_run && !mult_clock_select)
        else $error("power down did not clear multiplier");

    chk_no_restore: assert property (
        !s_q.act_en && !commit |=> !s_q.act_en)
        else $error("enable came back without commit");

    chk_source_sel: assert property (
        mult_clock_select |-> mult_run && s_q.act_en && s_q.act_con)
        else $error("clock selected without enable and connect");

    chk_run_follow: assert property (
        ##1 ($past(commit)
            || mult_run == ($past(s_q.act_en) && !$past(power_down_enter))))
        else $error("run output does not follow enable");

    chk_factor_map: assert property (
        ##1 mult_factor == 6'($past(s_q.act_multiplier_field)) + 6'h01
            || $past(commit) || $past(power_down_enter))
        else $error("multiplier factor wrong");

    chk_div_map: assert property (
        ##1 cco_divide == (5'h02 << $past(s_q.act_psel)) || $past(commit))
        else $error("divider mapping wrong");

    chk_status_read: assert property (
        bus_req.valid && !bus_req.write && bus_req.addr == PFC_STAT_ADDR
        |=> bus_rdata[10] == $past(s_q.lock_sync)
            && bus_rdata[4:0] == $past(s_q.act_multiplier_field))
        else $error("status read back wrong");

    chk_lock_sync: assert property (
        lock_raw [*3] |-> lock_flag)
        else $error("lock flag not synchronised");

    // one read request on the register bus, decoded by address
    sequence seq_read_of(logic [31:0] addr_v);
        bus_req.valid && !bus_req.write && bus_req.addr == addr_v;
    endsequence

    chk_ctl_readback: assert property (
        seq_read_of(PFC_CTL_ADDR) |=> bus_rdata[1:0] == $past(s_q.pend_ctl))
        else $error("control read back wrong");

    chk_stat_bits: assert property (
        seq_read_of(PFC_STAT_ADDR)
        |=> bus_rdata[9:8] == {$past(s_q.act_con), $past(s_q.act_en)}
            && bus_rdata[6:5] == $past(s_q.act_psel))
        else $error("status enable, connect or divider wrong");

    chk_unlock_zero: assert property (
        seq_read_of(PFC_UNLOCK_ADDR) |=> bus_rdata == PFC_RDATA_RESET)
        else $error("unlock register did not read zero");

    chk_commit_cfg: assert property (
        commit |=> s_q.act_multiplier_field == $past(s_q.pend_cfg[4:0])
            && s_q.act_psel == $past(s_q.pend_cfg[6:5]))
        else $error("commit did not copy pending configuration");

    chk_select_needs_enable: assert property (
        !s_q.act_en && !commit |=> !mult_clock_select)
        else $error("clock selected while multiplier disabled");

    chk_pd_pending: assert property (
        power_down_enter && !bus_req.valid
        |=> $stable(s_q.pend_ctl) && $stable(s_q.pend_cfg))
        else $error("power down disturbed pending values");

endmodule
`default_nettype wire

// *** hw/pfc_pkg.sv ***
package pfc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [31:0] PFC_CTL_ADDR    = 32'he01fc080;
    localparam logic [31:0] PFC_CFG_ADDR    = 32'he01fc084;
    localparam logic [31:0] PFC_STAT_ADDR   = 32'he01fc088;
    localparam logic [31:0] PFC_UNLOCK_ADDR = 32'he01fc08c;

    localparam logic [7:0]  PFC_KEY_FIRST  = 8'haa;
    localparam logic [7:0]  PFC_KEY_SECOND = 8'h55;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int PFC_CTL_EN_BIT   = 0;
    localparam int PFC_CTL_CON_BIT  = 1;
    localparam int PFC_MULTIPLIER_FIELD_LSB     = 0;
    localparam int PFC_PSEL_LSB     = 5;
    localparam int PFC_STAT_EN_BIT  = 8;
    localparam int PFC_STAT_CON_BIT = 9;
    localparam int PFC_STAT_LCK_BIT = 10;

    localparam logic [4:0]  PFC_MULTIPLIER_FIELD_RESET = 5'h00;
    localparam logic [1:0]  PFC_PSEL_RESET = 2'h0;
    localparam logic [1:0]  PFC_CTL_RESET  = 2'h0;
    localparam logic [15:0] PFC_RDATA_RESET = 16'h0000;
    localparam logic [5:0]  PFC_FACTOR_RESET = 6'h01;
    localparam logic [4:0]  PFC_DIV_RESET    = 5'h02;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [7:0]  wdata;
    } pfc_bus_req_type;

    typedef enum logic {
        PFC_IDLE,
        PFC_ARMED
    } pfc_trk_state_type;

endpackage

// *** hw/pfc_unlock_tracker.sv ***
`timescale 1ns/1ps
`default_nettype none
module pfc_unlock_tracker (
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire pfc_pkg::pfc_bus_req_type req,
    output logic                          commit
);
    import pfc_pkg::*;

    typedef struct packed {
        pfc_trk_state_type st;
        logic              commit;
    } pfc_trk_type;

    pfc_trk_type s_q;
    pfc_trk_type s_d;
    logic        is_unlock_wr;

    assign is_unlock_wr = req.valid && req.write
                          && req.addr == PFC_UNLOCK_ADDR;

    // ------------------------------------------------------------
    // tracker
    // ------------------------------------------------------------
    // idle cycles do not disarm; only another bus access does
    always_comb begin
        s_d = s_q;
        s_d.commit = 1'b0;
        if (req.valid) begin
            s_d.st = PFC_IDLE;
            case (s_q.st)
                PFC_IDLE: begin
                    if (is_unlock_wr && req.wdata == PFC_KEY_FIRST) begin
                        s_d.st = PFC_ARMED;
                    end
                end
                PFC_ARMED: begin
                    if (is_unlock_wr && req.wdata == PFC_KEY_SECOND) begin
                        s_d.commit = 1'b1;
                    end else if (is_unlock_wr
                                 && req.wdata == PFC_KEY_FIRST) begin
                        s_d.st = PFC_ARMED;
                    end
                end
                default: s_d.st = PFC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_q <= '{st: PFC_IDLE, commit: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign commit = s_q.commit;

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    chk_foreign_disarm: assert property (
        req.valid && !is_unlock_wr |=> s_q.st == PFC_IDLE && !commit)
        else $error("foreign access did not disarm tracker");

    chk_second_key: assert property (
        commit |-> $past(s_q.st) == PFC_ARMED)
        else $error("commit without armed tracker");

endmodule
`default_nettype wire

// *** test/pfc_pll_feed_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module pfc_pll_feed_control_tb;
    import pfc_pkg::*;

    // ------------------------------------------------------------
    // signals and reference model
    // ------------------------------------------------------------
    logic            clock;
    logic            rst;
    pfc_bus_req_type bus_req;
    logic [15:0]     bus_rdata;
    logic            power_down_enter;
    logic            lock_raw;
    logic            lock_flag;
    logic            mult_run;
    logic            mult_clock_select;
    logic [5:0]      mult_factor;
    logic [4:0]      cco_divide;
    logic [1:0]      p_ctl;
    logic [1:0]      a_ctl;
    logic [6:0]      p_cfg;
    logic [6:0]      a_cfg;
    logic            lk;
    logic [31:0]     v;
    int              n_mismatch;
    int              compares;
    int              cyc;
    integer          seed;

    pfc_pll_feed_control u_dut (
        .clock             (clock),
        .rst               (rst),
        .bus_req           (bus_req),
        .bus_rdata         (bus_rdata),
        .power_down_enter  (power_down_enter),
        .lock_raw          (lock_raw),
        .lock_flag         (lock_flag),
        .mult_run          (mult_run),
        .mult_clock_select (mult_clock_select),
        .mult_factor       (mult_factor),
        .cco_divide        (cco_divide)
    );

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // ------------------------------------------------------------
    // expectations
    // ------------------------------------------------------------
    function automatic logic [15:0] exp_fac(input logic [4:0] m);
        return {11'h000, m} + 16'h0001;
    endfunction
    function automatic logic [15:0] exp_div(input logic [1:0] p);
        return 16'h0002 << p;
    endfunction
    // reserved bit 7 is left out of the compare, its value is undefined
    function automatic logic [15:0] exp_stat();
        return {5'h00, lk, a_ctl[1], a_ctl[0], 1'b0, a_cfg};
    endfunction

    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // valid is held between back-to-back calls, released by idle only
    task automatic acc(input logic w, input logic [31:0] a,
                       input logic [7:0] d);
        @(posedge clock);
        bus_req <= '{1'b1, w, a, d};
        if (w && a == PFC_CTL_ADDR) p_ctl = d[1:0];
        if (w && a == PFC_CFG_ADDR) p_cfg = d[6:0];
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clock);
            bus_req <= '0;
        end
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [15:0] e,
                         input logic [15:0] m);
        acc(1'b0, a, 8'h00);
        idle(1);
        #1;
        chk(bus_rdata & m, e & m);
    endtask
    task automatic feed(input int gap);
        acc(1'b1, PFC_UNLOCK_ADDR, PFC_KEY_FIRST);
        if (gap > 0) idle(gap);
        acc(1'b1, PFC_UNLOCK_ADDR, PFC_KEY_SECOND);
        a_ctl = p_ctl;
        a_cfg = p_cfg;
        idle(5);
    endtask
    task automatic chk_all();
        chk({15'h0, mult_run}, {15'h0, a_ctl[0]});
        chk({15'h0, mult_clock_select}, {15'h0, &a_ctl});
        chk({10'h0, mult_factor}, exp_fac(a_cfg[4:0]));
        chk({11'h0, cco_divide}, exp_div(a_cfg[6:5]));
        rdchk(PFC_STAT_ADDR, exp_stat(), 16'h077f);
    endtask

    // cuts a hung run short
    always @(posedge clock) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'hc90a;
        rst = 1'b1;
        bus_req = '0;
        power_down_enter = 1'b0;
        lock_raw = 1'b0;
        {p_ctl, a_ctl, p_cfg, a_cfg, lk} = '0;
        n_mismatch = 0;
        compares = 0;
        cyc = 0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        chk_all();
        rdchk(PFC_UNLOCK_ADDR, 16'h0000, 16'hffff);
        rdchk(32'he01fc090, 16'h0000, 16'hffff);
        for (int i = 0; i < 24; i++) begin
            v = $random(seed);
            acc(1'b1, PFC_CTL_ADDR, {6'h00, i < 16 ? 2'(i >> 2) : v[1:0]});
            acc(1'b1, PFC_CFG_ADDR, {1'b0, i < 16 ? 2'(i) : v[6:5],
                i == 0 ? 5'h00 : i == 1 ? 5'h1f : v[12:8]});
            rdchk(PFC_CTL_ADDR, {14'h0, p_ctl}, 16'h0003);
            rdchk(PFC_CFG_ADDR, {9'h0, p_cfg}, 16'h007f);
            if (i % 2 == 1) begin
                case ((i >> 1) % 4)
                    0: begin
                        acc(1'b1, PFC_UNLOCK_ADDR, PFC_KEY_SECOND);
                        acc(1'b1, PFC_UNLOCK_ADDR, PFC_KEY_FIRST);
                    end
                    1: begin
                        acc(1'b1, PFC_UNLOCK_ADDR, PFC_KEY_FIRST);
                        acc(1'b1, 32'he01fc090, 8'h00);
                        acc(1'b1, PFC_UNLOCK_ADDR, PFC_KEY_SECOND);
                    end
                    2: begin
                        acc(1'b1, PFC_UNLOCK_ADDR, PFC_KEY_FIRST);
                        acc(1'b0, PFC_STAT_ADDR, 8'h00);
                        acc(1'b1, PFC_UNLOCK_ADDR, PFC_KEY_SECOND);
                    end
                    default: begin
                        acc(1'b1, PFC_UNLOCK_ADDR, PFC_KEY_FIRST);
                        acc(1'b1, PFC_UNLOCK_ADDR, 8'h56);
                    end
                endcase
                idle(5);
                chk_all();
            end
            feed(i % 3);
            chk_all();
        end
        // power down with the multiplier connected
        acc(1'b1, PFC_CTL_ADDR, 8'h03);
        acc(1'b1, PFC_CFG_ADDR, 8'h25);
        feed(0);
        @(posedge clock);
        power_down_enter <= 1'b1;
        @(posedge clock);
        power_down_enter <= 1'b0;
        a_ctl = 2'h0;
        idle(3);
        chk_all();
        idle(20);
        acc(1'b1, PFC_STAT_ADDR, 8'hff);
        idle(1);
        chk_all();
        // restart: enable, wait for lock, then connect
        acc(1'b1, PFC_CTL_ADDR, 8'h01);
        feed(0);
        lock_raw <= 1'b1;
        lk = 1'b1;
        idle(4);
        chk({15'h0, lock_flag}, 16'h0001);
        chk_all();
        acc(1'b1, PFC_CTL_ADDR, 8'h03);
        feed(0);
        chk_all();
        lock_raw <= 1'b0;
        lk = 1'b0;
        idle(4);
        chk_all();
        close_out();
    end
endmodule
`default_nettype wire
